// ==== rtl/ext_prop_pkg.sv ====
// constants for the extended property bank
package ext_prop_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int REG_BYTES = 512;
   localparam int PROP_BYTES = 320;
   localparam int MODE_BYTES = 192;
   localparam logic [9:0] PROP_BASE = 10'h0c0;
   // ----------------------------------------
   // bus map (word index = byte address / 4)
   // ----------------------------------------
   localparam logic [7:0] WORD_COUNT = 8'h80;
   localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
   // ----------------------------------------
   // property byte offsets
   // ----------------------------------------
   localparam logic [9:0] OFS_SECURE_TRIM = 10'h0e5;
   localparam logic [9:0] OFS_SECURE_ERASE = 10'h0e6;
   localparam logic [9:0] OFS_SECURE_FLAGS = 10'h0e7;
   localparam logic [9:0] OFS_UNMAP_FACTOR = 10'h0e8;
   localparam logic [9:0] OFS_DDR52_RD_PERF = 10'h0ea;
   localparam logic [9:0] OFS_DDR52_WR_PERF = 10'h0eb;
   localparam logic [9:0] OFS_HS200_LOW_PWR = 10'h0ec;
   localparam logic [9:0] OFS_HS200_HIGH_PWR = 10'h0ed;
   localparam logic [9:0] OFS_DDR52_LOW_PWR = 10'h0ee;
   localparam logic [9:0] OFS_DDR52_HIGH_PWR = 10'h0ef;
   localparam logic [9:0] OFS_FLUSH_POLICY = 10'h0f0;
   localparam logic [9:0] OFS_FIRST_INIT_TO = 10'h0f1;
   localparam logic [9:0] OFS_GOOD_SECTORS = 10'h0f2;
   localparam logic [9:0] OFS_BG_LEVEL = 10'h0f6;
   localparam logic [9:0] OFS_POWEROFF_TO = 10'h0f7;
   localparam logic [9:0] OFS_SWITCH_TO = 10'h0f8;
   localparam logic [9:0] OFS_BUF_CAPACITY = 10'h0f9;
   localparam logic [9:0] OFS_HS400_PWR = 10'h0fd;
   localparam logic [9:0] OFS_CODE_REV = 10'h0fe;
   localparam logic [9:0] OFS_PART_REV = 10'h106;
   localparam logic [9:0] OFS_UNMAP_GRAN = 10'h108;
   localparam logic [9:0] OFS_WRITE_GRAN = 10'h109;
   localparam logic [9:0] OFS_READ_GRAN = 10'h10a;
   localparam logic [9:0] OFS_EOL_WARN = 10'h10b;
   localparam logic [9:0] OFS_WEAR_FIRST = 10'h10c;
   localparam logic [9:0] OFS_WEAR_SECOND = 10'h10d;
   localparam logic [9:0] OFS_HEALTH_AREA = 10'h10e;
   localparam logic [9:0] OFS_UPDATE_SECTORS = 10'h12e;
   localparam logic [9:0] OFS_QUEUE_SLOTS = 10'h133;
   localparam logic [9:0] OFS_QUEUE_CAPS = 10'h134;
   localparam logic [9:0] OFS_FENCE_CAPS = 10'h1e6;
   localparam logic [9:0] OFS_UPDATE_ARG = 10'h1e7;
   localparam logic [9:0] OFS_OPCODE_TO = 10'h1eb;
   localparam logic [9:0] OFS_UPDATE_FEAT = 10'h1ec;
   localparam logic [9:0] OFS_OPER_MODES = 10'h1ed;
   localparam logic [9:0] OFS_PART_ATTR = 10'h1ee;
   localparam logic [9:0] OFS_BIG_UNIT = 10'h1ef;
   localparam logic [9:0] OFS_CONTEXT_CAPS = 10'h1f0;
   localparam logic [9:0] OFS_LABEL_RES = 10'h1f1;
   localparam logic [9:0] OFS_LABEL_UNIT = 10'h1f2;
   localparam logic [9:0] OFS_LABEL_CAPS = 10'h1f3;
   localparam logic [9:0] OFS_BUNDLE_WR = 10'h1f4;
   localparam logic [9:0] OFS_BUNDLE_RD = 10'h1f5;
   localparam logic [9:0] OFS_BG_CAPS = 10'h1f6;
   localparam logic [9:0] OFS_PRIO_INT = 10'h1f7;
   localparam logic [9:0] OFS_CMD_SET_CAPS = 10'h1f8;
   localparam logic [9:0] OFS_SEC_FAULT = 10'h1f9;
   // ----------------------------------------
   // property values
   // ----------------------------------------
   localparam logic [7:0] VAL_SECURE_TRIM = 8'h0a;
   localparam logic [7:0] VAL_SECURE_ERASE = 8'h64;
   localparam logic [7:0] VAL_SECURE_FLAGS = 8'h55;
   localparam logic [7:0] VAL_UNMAP_FACTOR = 8'h02;
   localparam logic [7:0] VAL_DDR52_RD_PERF = 8'h8c;
   localparam logic [7:0] VAL_DDR52_WR_PERF = 8'h78;
   localparam logic [7:0] VAL_HS200_LOW_PWR = 8'h00;
   localparam logic [7:0] VAL_HS200_HIGH_PWR = 8'h22;
   localparam logic [7:0] VAL_DDR52_LOW_PWR = 8'h00;
   localparam logic [7:0] VAL_DDR52_HIGH_PWR = 8'h11;
   localparam logic [7:0] VAL_FLUSH_POLICY = 8'h01;
   localparam logic [7:0] VAL_FIRST_INIT_TO = 8'h0a;
   localparam logic [31:0] VAL_GOOD_SECTORS = 32'h00000000;
   localparam logic [7:0] VAL_BG_LEVEL = 8'h00;
   localparam logic [7:0] VAL_POWEROFF_TO = 8'h64;
   localparam logic [7:0] VAL_SWITCH_TO = 8'h05;
   localparam logic [31:0] VAL_BUF_CAPACITY = 32'h00000400;
   localparam logic [7:0] VAL_HS400_PWR = 8'h22;
   localparam logic [63:0] VAL_CODE_REV = 64'h0000000000000001;
   localparam logic [15:0] VAL_PART_REV = 16'h0001;
   localparam logic [7:0] VAL_UNMAP_GRAN = 8'h07;
   localparam logic [7:0] VAL_WRITE_GRAN = 8'h40;
   localparam logic [7:0] VAL_READ_GRAN = 8'h40;
   localparam logic [7:0] VAL_EOL_WARN = 8'h01;
   localparam logic [7:0] VAL_WEAR_FIRST = 8'h01;
   localparam logic [7:0] VAL_WEAR_SECOND = 8'h01;
   localparam logic [7:0] VAL_HEALTH_BYTE = 8'h00;
   localparam logic [31:0] VAL_UPDATE_SECTORS = 32'h00000000;
   localparam logic [7:0] VAL_QUEUE_SLOTS = 8'h1f;
   localparam logic [7:0] VAL_QUEUE_CAPS = 8'h01;
   localparam logic [7:0] VAL_FENCE_CAPS = 8'h01;
   localparam logic [31:0] VAL_UPDATE_ARG = 32'hfffafff0;
   localparam logic [7:0] VAL_OPCODE_TO = 8'h00;
   localparam logic [7:0] VAL_UPDATE_FEAT = 8'h00;
   localparam logic [7:0] VAL_OPER_MODES = 8'h01;
   localparam logic [7:0] VAL_PART_ATTR = 8'h03;
   localparam logic [7:0] VAL_BIG_UNIT = 8'h01;
   localparam logic [7:0] VAL_CONTEXT_CAPS = 8'h78;
   localparam logic [7:0] VAL_LABEL_RES = 8'h00;
   localparam logic [7:0] VAL_LABEL_UNIT = 8'h00;
   localparam logic [7:0] VAL_LABEL_CAPS = 8'h01;
   localparam logic [7:0] VAL_BUNDLE_WR = 8'h3f;
   localparam logic [7:0] VAL_BUNDLE_RD = 8'h3f;
   localparam logic [7:0] VAL_BG_CAPS = 8'h01;
   localparam logic [7:0] VAL_PRIO_INT = 8'h01;
   localparam logic [7:0] VAL_CMD_SET_CAPS = 8'h01;
   localparam logic [7:0] VAL_SEC_FAULT = 8'h00;
   localparam logic [7:0] VAL_RESERVED = 8'h00;
   localparam logic [7:0] VAL_MODE_RESET = 8'h00;
endpackage

// ==== rtl/byte_lane_if.sv ====
// byte lookup path between the bus slave and the property rom
`timescale 1ns/1ps
interface byte_lane_if;
   logic [9:0] byteIndex [4];
   logic [7:0] byteValue [4];
   logic [3:0] inProps;
   modport requester (output byteIndex, input byteValue, input inProps);
   modport responder (input byteIndex, output byteValue, output inProps);
endinterface

// ==== rtl/ext_prop_rom.sv ====
// constant property bytes, four lanes looked up in parallel
`timescale 1ns/1ps
module ext_prop_rom (
   // lookup lanes
   byte_lane_if.responder lane
);
   // ----------------------------------------
   // byte lookup
   // ----------------------------------------
   function automatic logic [7:0] prop_byte(input logic [9:0] idx);
      logic [7:0] v;
      v = ext_prop_pkg::VAL_RESERVED; // R16
      case (idx)
         ext_prop_pkg::OFS_SECURE_TRIM: v = ext_prop_pkg::VAL_SECURE_TRIM;
         ext_prop_pkg::OFS_SECURE_ERASE: v = ext_prop_pkg::VAL_SECURE_ERASE;
         ext_prop_pkg::OFS_SECURE_FLAGS: v = ext_prop_pkg::VAL_SECURE_FLAGS;
         ext_prop_pkg::OFS_UNMAP_FACTOR: v = ext_prop_pkg::VAL_UNMAP_FACTOR;
         ext_prop_pkg::OFS_DDR52_RD_PERF: v = ext_prop_pkg::VAL_DDR52_RD_PERF;
         ext_prop_pkg::OFS_DDR52_WR_PERF: v = ext_prop_pkg::VAL_DDR52_WR_PERF; // R15
         ext_prop_pkg::OFS_HS200_LOW_PWR: v = ext_prop_pkg::VAL_HS200_LOW_PWR;
         ext_prop_pkg::OFS_HS200_HIGH_PWR: v = ext_prop_pkg::VAL_HS200_HIGH_PWR;
         ext_prop_pkg::OFS_DDR52_LOW_PWR: v = ext_prop_pkg::VAL_DDR52_LOW_PWR;
         ext_prop_pkg::OFS_DDR52_HIGH_PWR: v = ext_prop_pkg::VAL_DDR52_HIGH_PWR; // R14
         ext_prop_pkg::OFS_FLUSH_POLICY: v = ext_prop_pkg::VAL_FLUSH_POLICY;
         ext_prop_pkg::OFS_FIRST_INIT_TO: v = ext_prop_pkg::VAL_FIRST_INIT_TO;
         ext_prop_pkg::OFS_BG_LEVEL: v = ext_prop_pkg::VAL_BG_LEVEL;
         ext_prop_pkg::OFS_POWEROFF_TO: v = ext_prop_pkg::VAL_POWEROFF_TO; // R12
         ext_prop_pkg::OFS_SWITCH_TO: v = ext_prop_pkg::VAL_SWITCH_TO;
         ext_prop_pkg::OFS_HS400_PWR: v = ext_prop_pkg::VAL_HS400_PWR; // R13
         ext_prop_pkg::OFS_PART_REV: v = ext_prop_pkg::VAL_PART_REV[7:0];
         ext_prop_pkg::OFS_PART_REV + 10'h001: v = ext_prop_pkg::VAL_PART_REV[15:8];
         ext_prop_pkg::OFS_UNMAP_GRAN: v = ext_prop_pkg::VAL_UNMAP_GRAN;
         ext_prop_pkg::OFS_WRITE_GRAN: v = ext_prop_pkg::VAL_WRITE_GRAN;
         ext_prop_pkg::OFS_READ_GRAN: v = ext_prop_pkg::VAL_READ_GRAN;
         ext_prop_pkg::OFS_EOL_WARN: v = ext_prop_pkg::VAL_EOL_WARN;
         ext_prop_pkg::OFS_WEAR_FIRST: v = ext_prop_pkg::VAL_WEAR_FIRST; // R11
         ext_prop_pkg::OFS_WEAR_SECOND: v = ext_prop_pkg::VAL_WEAR_SECOND; // R10
         ext_prop_pkg::OFS_QUEUE_SLOTS: v = ext_prop_pkg::VAL_QUEUE_SLOTS;
         ext_prop_pkg::OFS_QUEUE_CAPS: v = ext_prop_pkg::VAL_QUEUE_CAPS;
         ext_prop_pkg::OFS_FENCE_CAPS: v = ext_prop_pkg::VAL_FENCE_CAPS;
         ext_prop_pkg::OFS_OPCODE_TO: v = ext_prop_pkg::VAL_OPCODE_TO;
         ext_prop_pkg::OFS_UPDATE_FEAT: v = ext_prop_pkg::VAL_UPDATE_FEAT;
         ext_prop_pkg::OFS_OPER_MODES: v = ext_prop_pkg::VAL_OPER_MODES;
         ext_prop_pkg::OFS_PART_ATTR: v = ext_prop_pkg::VAL_PART_ATTR; // R7
         ext_prop_pkg::OFS_BIG_UNIT: v = ext_prop_pkg::VAL_BIG_UNIT;
         ext_prop_pkg::OFS_CONTEXT_CAPS: v = ext_prop_pkg::VAL_CONTEXT_CAPS;
         ext_prop_pkg::OFS_LABEL_RES: v = ext_prop_pkg::VAL_LABEL_RES;
         ext_prop_pkg::OFS_LABEL_UNIT: v = ext_prop_pkg::VAL_LABEL_UNIT;
         ext_prop_pkg::OFS_LABEL_CAPS: v = ext_prop_pkg::VAL_LABEL_CAPS;
         ext_prop_pkg::OFS_BUNDLE_WR: v = ext_prop_pkg::VAL_BUNDLE_WR; // R6
         ext_prop_pkg::OFS_BUNDLE_RD: v = ext_prop_pkg::VAL_BUNDLE_RD; // R5
         ext_prop_pkg::OFS_BG_CAPS: v = ext_prop_pkg::VAL_BG_CAPS;
         ext_prop_pkg::OFS_PRIO_INT: v = ext_prop_pkg::VAL_PRIO_INT;
         ext_prop_pkg::OFS_CMD_SET_CAPS: v = ext_prop_pkg::VAL_CMD_SET_CAPS;
         ext_prop_pkg::OFS_SEC_FAULT: v = ext_prop_pkg::VAL_SEC_FAULT; // R4
         default: begin
            // multi-byte fields, low byte at the low index
            if (idx >= ext_prop_pkg::OFS_GOOD_SECTORS && idx < ext_prop_pkg::OFS_BG_LEVEL) begin
               v = ext_prop_pkg::VAL_GOOD_SECTORS[8 * (idx - ext_prop_pkg::OFS_GOOD_SECTORS) +: 8]; // R16
            end else if (idx >= ext_prop_pkg::OFS_BUF_CAPACITY && idx < ext_prop_pkg::OFS_HS400_PWR) begin
               v = ext_prop_pkg::VAL_BUF_CAPACITY[8 * (idx - ext_prop_pkg::OFS_BUF_CAPACITY) +: 8];
            end else if (idx >= ext_prop_pkg::OFS_CODE_REV && idx < ext_prop_pkg::OFS_PART_REV) begin
               v = ext_prop_pkg::VAL_CODE_REV[8 * (idx - ext_prop_pkg::OFS_CODE_REV) +: 8];
            end else if (idx >= ext_prop_pkg::OFS_HEALTH_AREA && idx < ext_prop_pkg::OFS_UPDATE_SECTORS) begin
               v = ext_prop_pkg::VAL_HEALTH_BYTE; // R9
            end else if (idx >= ext_prop_pkg::OFS_UPDATE_SECTORS && idx < ext_prop_pkg::OFS_UPDATE_SECTORS + 10'h004) begin
               v = ext_prop_pkg::VAL_UPDATE_SECTORS[8 * (idx - ext_prop_pkg::OFS_UPDATE_SECTORS) +: 8]; // R8
            end else if (idx >= ext_prop_pkg::OFS_UPDATE_ARG && idx < ext_prop_pkg::OFS_OPCODE_TO) begin
               v = ext_prop_pkg::VAL_UPDATE_ARG[8 * (idx - ext_prop_pkg::OFS_UPDATE_ARG) +: 8];
            end
         end
      endcase
      return v;
   endfunction

   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign lane.byteValue[i] = prop_byte(lane.byteIndex[i]);
      assign lane.inProps[i] = (lane.byteIndex[i] >= ext_prop_pkg::PROP_BASE); // R2
   end
endmodule // ext_prop_rom

// ==== rtl/ext_prop_bank.sv ====
// wishbone slave for the 512-byte extended configuration register
`timescale 1ns/1ps
// Operation
// R1: one contiguous 512-byte register
// R2: upper 320 bytes constant, writes ignored
// R3: lower 192 bytes writable mode bytes
// R4: byte 505 reads 0x00
// R5: byte 501 reads 0x3f
// R6: byte 500 reads 0x3f
// R7: byte 494 reads 0x03
// R8: bytes 305..302 read zero
// R9: bytes 301..270 hold no defined content
// R10: byte 269 reads 0x01
// R11: byte 268 reads 0x01
// R12: byte 247 reads 0x64
// R13: byte 253 reads 0x22
// R14: byte 239 reads 0x11
// R15: byte 235 reads 0x78
// R16: reserved reads zero, little-endian multi-byte fields
module ext_prop_bank (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [8:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [1:0] {
      IDLE = 2'b01,
      DONE = 2'b10
   } bus_state_t;

   bus_state_t state_reg;
   bus_state_t state_next;
   logic [7:0] modeBytes [ext_prop_pkg::MODE_BYTES];
   logic [31:0] readData_reg;
   logic ack_reg;
   byte_lane_if lane ();

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // word address is the byte address divided by four
   wire logic [6:0] wordIdx = adr_i[8:2];
   wire logic request = cyc_i && stb_i && (state_reg == IDLE);
   wire logic [7:0] wordLimit = ext_prop_pkg::WORD_COUNT;
   wire logic inRange = ({1'b0, wordIdx} < wordLimit); // R1
   wire logic [31:0] wordData;

   for (genvar i = 0; i < 4; i++) begin : g_byte
      wire logic [9:0] idx = {1'b0, wordIdx, 2'(i)};
      assign lane.byteIndex[i] = idx;
      // modes from the array, properties from the rom
      assign wordData[8 * i +: 8] = lane.inProps[i] ? lane.byteValue[i] : modeBytes[idx[7:0]]; // R16
   end

   ext_prop_rom rom (
      .lane(lane)
   );

   // ----------------------------------------
   // handshake
   // ----------------------------------------
   always_comb begin
      case (state_reg)
         IDLE: state_next = request ? DONE : IDLE;
         DONE: state_next = IDLE;
         default: state_next = IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= IDLE;
         ack_reg <= 1'b0;
         readData_reg <= ext_prop_pkg::UNMAPPED_DATA;
      end else begin
         state_reg <= state_next;
         ack_reg <= request;
         if (request) begin
            readData_reg <= inRange ? wordData : ext_prop_pkg::UNMAPPED_DATA;
         end
      end
   end

   // ----------------------------------------
   // mode segment writes
   // ----------------------------------------
   // property bytes have no storage, so a write there simply drops
   always_ff @(posedge clock) begin
      if (srst) begin
         for (int b = 0; b < ext_prop_pkg::MODE_BYTES; b++) begin
            modeBytes[b] <= ext_prop_pkg::VAL_MODE_RESET;
         end
      end else if (request && we_i) begin
         for (int i = 0; i < 4; i++) begin
            if (sel_i[i] && !lane.inProps[i]) begin
               modeBytes[lane.byteIndex[i][7:0]] <= dat_i[8 * i +: 8]; // R3
            end
         end
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = readData_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_ack_follows: assert property (@(posedge clock) disable iff (srst) request |=> ack_o) // R1
      else $error("ack missing after request");
   chk_ack_single: assert property (@(posedge clock) disable iff (srst) ack_o |=> !ack_o)
      else $error("ack held two cycles");
   chk_sec_fault: assert property (@(posedge clock) disable iff (srst)
      (request && !we_i && wordIdx == 7'h7e) |=> dat_o[15:8] == 8'h00) // R4
      else $error("byte 505 not zero");
   chk_bundle_limits: assert property (@(posedge clock) disable iff (srst)
      (request && !we_i && wordIdx == 7'h7d) |=> dat_o[15:0] == 16'h3f3f) // R5
      else $error("packed limits wrong");
   chk_part_attr: assert property (@(posedge clock) disable iff (srst)
      (request && wordIdx == 7'h7b) |=> dat_o[23:16] == 8'h03) // R7
      else $error("byte 494 wrong");
   chk_wear_bytes: assert property (@(posedge clock) disable iff (srst)
      (request && wordIdx == 7'h43) |=> dat_o[15:0] == 16'h0101) // R10
      else $error("wear estimates wrong");
   chk_poweroff_time: assert property (@(posedge clock) disable iff (srst)
      (request && wordIdx == 7'h3d) |=> dat_o[31:24] == 8'h64) // R12
      else $error("byte 247 wrong");
   chk_power_classes: assert property (@(posedge clock) disable iff (srst)
      (request && wordIdx == 7'h3b) |=> dat_o[31:24] == 8'h11 && dat_o[23:16] == 8'h00) // R14
      else $error("byte 239 wrong");
   chk_hs400_class: assert property (@(posedge clock) disable iff (srst)
      (request && wordIdx == 7'h3f) |=> dat_o[15:8] == 8'h22) // R13
      else $error("byte 253 wrong");
   chk_write_perf: assert property (@(posedge clock) disable iff (srst)
      (request && wordIdx == 7'h3a) |=> dat_o[31:24] == 8'h78) // R15
      else $error("byte 235 wrong");
   chk_update_count: assert property (@(posedge clock) disable iff (srst)
      (request && wordIdx == 7'h4b) |=> dat_o[31:16] == 16'h0000 ##1 1'b1) // R8
      else $error("update sectors not zero");
   chk_props_const: assert property (@(posedge clock) disable iff (srst)
      (request && wordIdx == 7'h7d) |=> dat_o[7:0] == 8'h3f) // R6
      else $error("byte 500 wrong");

   cov_read: cover property (@(posedge clock) disable iff (srst) request && !we_i ##1 ack_o);
   cov_mode_write: cover property (@(posedge clock) disable iff (srst) request && we_i && wordIdx < 7'h30);
   cov_prop_write: cover property (@(posedge clock) disable iff (srst) request && we_i && wordIdx >= 7'h30);
endmodule // ext_prop_bank

// ==== verif/card_host_model.sv ====
// wishbone host model standing in for the card bus host controller
`timescale 1ns/1ps
module card_host_model (
   // clock
   input wire logic clock,
   // wishbone master side
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [8:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat,
   input wire logic [31:0] rdat,
   input wire logic ack,
   // status
   output logic timedOut
);
   // ----------------------------------------
   // idle state at time zero
   // ----------------------------------------
   initial begin
      cyc = 1'h0;
      stb = 1'h0;
      we = 1'h0;
      adr = 9'h000;
      sel = 4'h0;
      dat = 32'h00000000;
      timedOut = 1'h0;
   end
   // ----------------------------------------
   // one classic cycle
   // ----------------------------------------
   // idle cycles before the request mimic a slow host; the wait for ack is bounded
   task automatic access(input logic wr, input logic [8:0] a, input logic [3:0] s, input logic [31:0] d,
         input int idle, output logic [31:0] q);
      int n;
      repeat (idle) @(posedge clock);
      @(posedge clock);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= wr;
      adr <= a;
      sel <= s;
      dat <= d;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'h1 && n < 64);
      if (ack !== 1'h1) timedOut = 1'h1;
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      // released lines must not keep showing the old request
      adr <= ~a;
      sel <= ~s;
      dat <= ~d;
   endtask
endmodule // card_host_model

// ==== verif/extended_device_property_bank_tb_top.sv ====
// self-checking bench for the extended property bank
`timescale 1ns/1ps
module extended_device_property_bank_tb_top;
   // ----------------------------------------
   // signals and bench state
   // ----------------------------------------
   logic clock;
   logic srst;
   logic cyc, stb, we, ack, timedOut;
   logic [8:0] adr;
   logic [3:0] sel;
   logic [31:0] datW, datR;
   logic [7:0] modeShadow [192];
   logic [31:0] rngState = 32'h4834;
   int errCount = 0;
   int checkCount = 0;

   ext_prop_bank i_dut (.clock(clock), .srst(srst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack));
   card_host_model i_host (.clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(datW),
      .rdat(datR), .ack(ack), .timedOut(timedOut));

   initial begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end
   // ----------------------------------------
   // expectations
   // ----------------------------------------
   function logic [31:0] nextRand();
      rngState = rngState ^ (rngState << 13);
      rngState = rngState ^ (rngState >> 17);
      rngState = rngState ^ (rngState << 5);
      return rngState;
   endfunction
   // property bytes as the host must see them; unlisted bytes are reserved zero
   function automatic logic [7:0] propByte(input int b);
      case (b)
         229, 241: return 8'h0a;
         230, 247: return 8'h64;
         231: return 8'h55;
         232: return 8'h02;
         234: return 8'h8c;
         235, 496: return 8'h78;
         237, 253: return 8'h22;
         239: return 8'h11;
         240, 254, 262, 267, 268, 269, 308, 486, 493, 495, 499, 502, 503, 504: return 8'h01;
         248: return 8'h05;
         250: return 8'h04;
         264: return 8'h07;
         265, 266: return 8'h40;
         307: return 8'h1f;
         487: return 8'hf0;
         488, 490: return 8'hff;
         489: return 8'hfa;
         494: return 8'h03;
         500, 501: return 8'h3f;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [31:0] expWord(input int w);
      logic [31:0] v;
      for (int i = 0; i < 4; i++) v[i*8 +: 8] = (w*4+i < 192) ? modeShadow[w*4+i] : propByte(w*4+i);
      return v;
   endfunction
   // ----------------------------------------
   // reporting and bus tasks
   // ----------------------------------------
   task testDone();
      if (errCount == 0 && checkCount > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task bus(input logic wr, input int byteAdr, input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
      i_host.access(wr, 9'(byteAdr), s, d, int'(nextRand() % 3), q);
      if (timedOut) begin
         errCount++;
         $display("wrong value ack expected 1 seen 0");
         testDone();
      end
   endtask
   // low address bits are randomised: only the word index may matter
   task checkWord(input int w);
      logic [31:0] q;
      bus(1'h0, w*4 + int'(nextRand() % 4), 4'hf, nextRand(), q);
      check($sformatf("word %0d", w), q, expWord(w));
   endtask
   task chkByte(input int b, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'h0, b, 4'hf, nextRand(), q);
      check($sformatf("byte %0d", b), {24'h000000, q[(b%4)*8 +: 8]}, {24'h000000, exp});
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] q;
      logic [31:0] d;
      logic [3:0] s;
      int w;
      srst = 1'h1;
      for (int i = 0; i < 192; i++) modeShadow[i] = 8'h00;
      repeat (5) @(posedge clock);
      srst <= 1'h0;
      for (int i = 0; i < 128; i++) checkWord(i);
      // ones over every property word: none of them may move
      for (int i = 48; i < 128; i++) bus(1'h1, i*4, 4'hf, 32'hffffffff, q);
      for (int i = 48; i < 128; i++) checkWord(i);
      chkByte(505, 8'h00);
      chkByte(501, 8'h3f);
      chkByte(500, 8'h3f);
      chkByte(494, 8'h03);
      for (int b = 302; b < 306; b++) chkByte(b, 8'h00);
      chkByte(269, 8'h01);
      chkByte(268, 8'h01);
      chkByte(247, 8'h64);
      chkByte(253, 8'h22);
      chkByte(239, 8'h11);
      chkByte(235, 8'h78);
      chkByte(487, 8'hf0);
      chkByte(489, 8'hfa);
      chkByte(250, 8'h04);
      chkByte(509, 8'h00);
      for (int i = 0; i < 40; i++) begin
         w = 48 + int'(nextRand() % 80);
         bus(1'h1, w*4 + int'(nextRand() % 4), 4'(nextRand()), nextRand(), q);
         checkWord(w);
      end
      // mode bytes: partial lanes, back-to-back, interleaved reads
      for (int i = 0; i < 60; i++) begin
         w = int'(nextRand() % 48);
         s = 4'(nextRand());
         d = nextRand();
         bus(1'h1, w*4 + int'(nextRand() % 4), s, d, q);
         for (int k = 0; k < 4; k++) if (s[k]) modeShadow[w*4+k] = d[k*8 +: 8];
         if (i % 3 == 0) checkWord(int'(nextRand() % 48));
      end
      for (int i = 0; i < 48; i++) checkWord(i);
      // a second reset in mid-run clears the mode bytes again
      @(posedge clock);
      srst <= 1'h1;
      repeat (2) @(posedge clock);
      srst <= 1'h0;
      for (int i = 0; i < 192; i++) modeShadow[i] = 8'h00;
      for (int i = 0; i < 64; i++) checkWord(i);
      testDone();
   end
endmodule // extended_device_property_bank_tb_top
